// ==== core/xdac_top.sv ====
/*
  Serial front end of an eight-channel twelve-bit converter: shift
  register, chained output, input and output registers, power modes.
  Assumes all pins arrive asynchronously to clk_i, and the serial clock
  runs well below a quarter of clk_i so each level is seen twice.
  In reset the synchronisers hold the pins' idle levels.
*/
`default_nettype none
`include "xdac_consts.svh"
module xdac_top
  import xdac_pkg::*;
(
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic din_i,
  input wire logic load_outputs_n_i,
  input wire logic async_clear_n_i,
  output logic dout_o,
  output logic [`XDAC_CHANNELS*`XDAC_CODE_BITS-1:0] dac_code_o,
  output logic [`XDAC_CHANNELS*2-1:0] chan_mode_o,
  output logic word_lost_o
);

  ////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [`XDAC_SY_BITS-1:0] sync1;
    logic [`XDAC_SY_BITS-1:0] sync2;
    logic [`XDAC_SY_BITS-1:0] prev;
    xdac_word_t shift;
    logic [`XDAC_CNT_BITS-1:0] cnt;
    logic dout;
    logic lost;
    logic [`XDAC_CHANNELS-1:0][`XDAC_CODE_BITS-1:0] inreg;
    logic [`XDAC_CHANNELS-1:0][`XDAC_CODE_BITS-1:0] dacreg;
    xdac_pwr_t [`XDAC_CHANNELS-1:0] mode;
  } xdac_state_t;

  xdac_state_t r;
  xdac_state_t n;

  xdac_stream_if #(.W(`XDAC_WORD_BITS)) push_if ();
  xdac_stream_if #(.W(`XDAC_WORD_BITS)) pop_if ();

  xdac_fifo #(
    .W(`XDAC_WORD_BITS),
    .DEPTH(`XDAC_FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .wr_if(push_if),
    .rd_if(pop_if)
  );

  ////////////////////////////////////////////////////////////////////
  // Decoders

  // Channels whose input register takes the data field
  function automatic logic [`XDAC_CHANNELS-1:0] in_mask(input logic [3:0] cmd);
    logic [`XDAC_CHANNELS-1:0] m;
    m = '0;
    case (cmd)
      XDAC_CMD_WT_LO: m = 8'h0f;
      XDAC_CMD_WT_HI: m = 8'hf0;
      XDAC_CMD_WT_ALL, XDAC_CMD_LOAD_ALL: m = 8'hff;
      default: begin
        if (cmd >= XDAC_CMD_LOAD1 && cmd <= XDAC_CMD_LOAD8) begin
          m = 8'h01 << 3'(cmd - XDAC_CMD_LOAD1);
        end
      end
    endcase
    return m;
  endfunction : in_mask

  // Channels whose output register follows in the same command
  function automatic logic [`XDAC_CHANNELS-1:0] thru_mask(input logic [3:0] cmd);
    logic [`XDAC_CHANNELS-1:0] m;
    m = '0;
    case (cmd)
      XDAC_CMD_WT_LO: m = 8'h0f;
      XDAC_CMD_WT_HI: m = 8'hf0;
      XDAC_CMD_WT_ALL: m = 8'hff;
      default: m = '0;
    endcase
    return m;
  endfunction : thru_mask

  // Registers and power modes as after power-up
  function automatic xdac_state_t cleared(input xdac_state_t s);
    xdac_state_t c;
    c = s;
    c.inreg = '0;
    c.dacreg = '0;
    c.mode = '{default: XDAC_PWR_SD3};
    return c;
  endfunction : cleared

  ////////////////////////////////////////////////////////////////////
  // Link edges and drain handshake

  logic cs_n;
  logic cs_fall;
  logic cs_rise;
  logic sclk_fall;
  logic load_n;
  logic clear_n;
  logic exec;
  logic [3:0] cmd;
  xdac_code_t code;
  logic [`XDAC_CHANNELS-1:0] mask;
  logic [`XDAC_CHANNELS-1:0] ld_m;
  logic [`XDAC_CHANNELS-1:0] th_m;
  xdac_pwr_t new_mode;

  assign cs_n = r.sync2[`XDAC_SY_CS];
  assign load_n = r.sync2[`XDAC_SY_LOAD];
  assign clear_n = r.sync2[`XDAC_SY_CLR];
  assign cs_fall = r.prev[`XDAC_SY_CS] & ~cs_n;
  assign cs_rise = ~r.prev[`XDAC_SY_CS] & cs_n;
  assign sclk_fall = r.prev[`XDAC_SY_SCLK] & ~r.sync2[`XDAC_SY_SCLK] & ~cs_n;

  // Whole words only; a short frame is dropped at select rise
  assign push_if.valid = cs_rise && (r.cnt == `XDAC_CNT_BITS'(`XDAC_WORD_BITS));
  assign push_if.data = r.shift;
  // Drain stalls while the clear pin is held
  assign pop_if.ready = clear_n;
  assign exec = pop_if.valid & pop_if.ready;

  assign cmd = pop_if.data[`XDAC_WORD_BITS-1:`XDAC_CMD_LSB];
  assign code = pop_if.data[`XDAC_CODE_BITS-1:0];
  assign mask = pop_if.data[`XDAC_CODE_BITS-1:`XDAC_MASK_LSB];
  assign new_mode = xdac_pwr_t'(pop_if.data[`XDAC_MODE_LSB+1:`XDAC_MODE_LSB]);
  assign ld_m = in_mask(cmd);
  assign th_m = thru_mask(cmd);

  ////////////////////////////////////////////////////////////////////
  // Per-channel mask decode

  logic [`XDAC_CHANNELS-1:0] xfer_m;
  logic [`XDAC_CHANNELS-1:0] pwr_m;

  for (genvar g = 0; g < `XDAC_CHANNELS; g++) begin : g_chan
    assign xfer_m[g] = (cmd == XDAC_CMD_XFER) & mask[g];
    assign pwr_m[g] = (cmd == XDAC_CMD_POWER) & mask[g];
  end

  ////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    n = r;
    n.sync1 = {async_clear_n_i, load_outputs_n_i, din_i, sclk_i, cs_n_i};
    n.sync2 = r.sync1;
    n.prev = r.sync2;
    n.lost = push_if.valid & ~push_if.ready;

    if (cs_fall) begin
      n.cnt = '0;
    end else if (sclk_fall) begin
      n.shift = {r.shift[`XDAC_WORD_BITS-2:0], r.sync2[`XDAC_SY_DIN]};
      n.dout = r.shift[`XDAC_WORD_BITS-1];
      // Saturates at sixteen; a longer frame keeps its last word
      if (r.cnt != `XDAC_CNT_BITS'(`XDAC_WORD_BITS)) begin
        n.cnt = `XDAC_CNT_BITS'(r.cnt + 1'b1);
      end
    end

    // Command word at the FIFO head
    if (exec) begin
      if (cmd == XDAC_CMD_RESET) begin
        n = cleared(n);
      end
      for (int i = 0; i < `XDAC_CHANNELS; i++) begin
        if (ld_m[i]) begin
          n.inreg[i] = code;
        end
        if (th_m[i]) begin
          n.dacreg[i] = code;
        end
        if (xfer_m[i]) begin
          n.dacreg[i] = r.inreg[i];
        end
        if (pwr_m[i]) begin
          n.mode[i] = new_mode;
        end
      end
    end

    if (!load_n) begin
      n.dacreg = n.inreg;
    end

    // Clear pin wins over load pin and commands
    if (!clear_n) begin
      n = cleared(n);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      r <= '0;
      // Idle pin levels, so release makes no false select or clear
      r.sync1 <= `XDAC_SY_IDLE;
      r.sync2 <= `XDAC_SY_IDLE;
      r.prev <= `XDAC_SY_IDLE;
    end else begin
      r <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Outputs

  assign dout_o = r.dout;
  assign dac_code_o = r.dacreg;
  assign chan_mode_o = r.mode;
  assign word_lost_o = r.lost;

endmodule : xdac_top
`default_nettype wire

// ==== core/xdac_consts.svh ====
/*
  Shared constants of the eight-channel converter serial front end.
  Assumes inclusion by bare name from the package and the top module.
*/
// Overview of operation
// - Shift input bits on serial clock falls
// - Low load input updates all outputs together
// - Load held low makes output registers transparent
// - Clear pin zeros input and output registers and power modes
// - Chained output changes on serial clock fall
// - Chained output passes shifted data onward
// - Eight channels, twelve-bit code each
// - Double buffered, separate or joint update
// - Reset leaves every output at zero
// - Serial command powers output buffers down
// - Sixteen-bit word: command nibble, twelve data, MSB first
// - Act only after sixteen edges and select rise
// - Decode commands for loads, write-through, transfer
// - Command fifteen sets power mode per mask
`ifndef XDAC_CONSTS_SVH
`define XDAC_CONSTS_SVH
`define XDAC_WORD_BITS 16
`define XDAC_CODE_BITS 12
`define XDAC_CHANNELS 8
`define XDAC_CNT_BITS 5
`define XDAC_FIFO_DEPTH 16
`define XDAC_CMD_LSB 12
`define XDAC_MASK_LSB 4
`define XDAC_MODE_LSB 2
`define XDAC_CODE_RST 12'h000
`define XDAC_SY_BITS 5
`define XDAC_SY_CS 0
`define XDAC_SY_SCLK 1
`define XDAC_SY_DIN 2
`define XDAC_SY_LOAD 3
`define XDAC_SY_CLR 4
`define XDAC_SY_IDLE 5'h19
`endif

// ==== core/xdac_pkg.sv ====
/*
  Types of the converter serial front end.
  Assumes xdac_consts.svh on the include path.
*/
`default_nettype none
`include "xdac_consts.svh"
package xdac_pkg;
  typedef logic [`XDAC_WORD_BITS-1:0] xdac_word_t;
  typedef logic [`XDAC_CODE_BITS-1:0] xdac_code_t;
  typedef enum logic [3:0] {
    XDAC_CMD_NOP = 4'h0,
    XDAC_CMD_RESET = 4'h1,
    XDAC_CMD_LOAD1 = 4'h2,
    XDAC_CMD_LOAD8 = 4'h9,
    XDAC_CMD_WT_LO = 4'ha,
    XDAC_CMD_WT_HI = 4'hb,
    XDAC_CMD_WT_ALL = 4'hc,
    XDAC_CMD_LOAD_ALL = 4'hd,
    XDAC_CMD_XFER = 4'he,
    XDAC_CMD_POWER = 4'hf
  } xdac_cmd_t;
  typedef enum logic [1:0] {
    XDAC_PWR_SD3 = 2'b00,
    XDAC_PWR_SD1 = 2'b01,
    XDAC_PWR_SD2 = 2'b10,
    XDAC_PWR_UP = 2'b11
  } xdac_pwr_t;
endpackage : xdac_pkg
`default_nettype wire

// ==== core/xdac_stream_if.sv ====
/*
  Valid/ready word carrier between the serial front end and its FIFO.
  Assumes one source and one sink on the same clock.
*/
`default_nettype none
interface xdac_stream_if #(parameter int W = 16);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : xdac_stream_if
`default_nettype wire

// ==== core/xdac_fifo.sv ====
/*
  Word FIFO with valid/ready on both sides.
  Assumes DEPTH is a power of two and a single clock.
*/
`default_nettype none
module xdac_fifo #(
  parameter int W = 16,
  parameter int DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  xdac_stream_if.snk wr_if,
  xdac_stream_if.src rd_if
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [PW-1:0] wptr;
    logic [PW-1:0] rptr;
    logic [CW-1:0] count;
  } xdac_fifo_state_t;

  xdac_fifo_state_t r;
  xdac_fifo_state_t n;
  logic push;
  logic pop;

  assign wr_if.ready = (r.count != CW'(DEPTH));
  assign rd_if.valid = (r.count != '0);
  assign rd_if.data = r.mem[r.rptr];
  assign push = wr_if.valid & wr_if.ready;
  assign pop = rd_if.valid & rd_if.ready;

  always_comb begin
    n = r;
    if (push) begin
      n.mem[r.wptr] = wr_if.data;
      n.wptr = PW'(r.wptr + 1'b1);
    end
    if (pop) begin
      n.rptr = PW'(r.rptr + 1'b1);
    end
    if (push && !pop) begin
      n.count = CW'(r.count + 1'b1);
    end else if (pop && !push) begin
      n.count = CW'(r.count - 1'b1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end
endmodule : xdac_fifo
`default_nettype wire

// ==== test/xdac_host.sv ====
/* Host model of the three-wire link.
   Assumes the bench calls send and reads rx. */
`default_nettype none
module xdac_host (
  output var logic cs_n_o,
  output var logic sclk_o,
  output var logic din_o,
  input wire logic dout_i
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] rx;
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    din_o = 1'b0;
    rx = 16'h0;
  end
  // Top n bits of w; rx gathers the chained output
  task automatic send(input logic [15:0] w, input int n);
    #37 cs_n_o = 1'b0;
    #400;
    for (int i = 0; i < n; i++) begin
      din_o = w[15-i];
      sclk_o = 1'b1;
      #400;
      if (i > 0) rx = {rx[14:0], dout_i};
      sclk_o = 1'b0;
      #400;
    end
    #400 rx = {rx[14:0], dout_i};
    cs_n_o = 1'b1;
    din_o = !din_o;
    #400;
  endtask : send
endmodule : xdac_host
`default_nettype wire

// ==== test/xdac_checker.sv ====
/* Pin checker of the converter front end.
   Bound onto xdac_top; sees its ports only. */
`default_nettype none
module xdac_checker (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic din_i,
  input wire logic load_outputs_n_i,
  input wire logic async_clear_n_i,
  input wire logic dout_o,
  input wire logic [95:0] dac_code_o,
  input wire logic [15:0] chan_mode_o,
  input wire logic word_lost_o
);
  logic cs_r;
  logic [5:0] quiet_r;
  logic [5:0] quiet_nxt;
  // Cycles since anything allowed to move outputs
  always_comb begin
    quiet_nxt = quiet_r + {5'h0, quiet_r != 6'h3f};
    if ((cs_n_i && !cs_r) || !load_outputs_n_i || !async_clear_n_i) quiet_nxt = 6'h0;
  end
  always_ff @(posedge clk_i) begin
    cs_r <= cs_n_i;
    quiet_r <= nrst_i ? quiet_nxt : 6'h0;
  end
  ////////////////
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);
  clr_code_a: assert property ((!async_clear_n_i) [*5] |-> !dac_code_o)
    else $error("codes kept under clear");
  clr_mode_a: assert property ((!async_clear_n_i) [*5] |-> !chan_mode_o)
    else $error("modes kept under clear");
  rst_zero_a: assert property ($rose(nrst_i) |-> !dac_code_o && !chan_mode_o)
    else $error("outputs set after reset");
  quiet_code_a: assert property (quiet_r > 6'h30 |-> $stable(dac_code_o))
    else $error("codes moved idle");
  quiet_mode_a: assert property (quiet_r > 6'h30 |-> $stable(chan_mode_o))
    else $error("modes moved idle");
  dout_fall_a: assert property ($changed(dout_o) && !cs_n_i |->
    !$past(sclk_i, 2) && ($past(sclk_i, 4) || $past(sclk_i, 5) || $past(sclk_i, 6)))
    else $error("chain out off a fall");
  dout_idle_a: assert property ((cs_n_i && async_clear_n_i) [*8] |=> $stable(dout_o))
    else $error("chain out moved idle");
  lost_one_a: assert property (word_lost_o |=> !word_lost_o)
    else $error("loss flag too long");
  lost_c: cover property (word_lost_o);
  load_c: cover property (!load_outputs_n_i && $changed(dac_code_o));
  pwr_c: cover property (chan_mode_o == 16'hffff);
endmodule : xdac_checker
bind xdac_top xdac_checker u_xdac_checker (.clk_i, .nrst_i, .cs_n_i, .sclk_i, .din_i,
  .load_outputs_n_i, .async_clear_n_i, .dout_o, .dac_code_o, .chan_mode_o, .word_lost_o);
`default_nettype wire

// ==== test/octal_dac_serial_register_control_test.sv ====
/* Self-checking bench of the converter front end.
   Assumes the host model drives the link pins. */
`default_nettype none
module octal_dac_serial_register_control_test
  import xdac_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic load_n = 1'b1;
  logic clr_n = 1'b1;
  wire cs_n, sclk, din, dout, lost;
  wire [95:0] code;
  wire [15:0] mode;
  logic [95:0] ec = '0;
  logic [15:0] em = '0;
  int err_total = 0;
  int checks_done = 0;
  int lost_n = 0;
  always #50 clk_i = !clk_i;
  always @(posedge clk_i) if (lost === 1'b1) lost_n++;
  xdac_host u_xdac_host (.cs_n_o(cs_n), .sclk_o(sclk), .din_o(din), .dout_i(dout));
  xdac_top u_xdac_top (.clk_i, .nrst_i, .cs_n_i(cs_n), .sclk_i(sclk), .din_i(din),
    .load_outputs_n_i(load_n), .async_clear_n_i(clr_n), .dout_o(dout),
    .dac_code_o(code), .chan_mode_o(mode), .word_lost_o(lost));
  ////////////////
  task automatic check(input logic [95:0] seen, input logic [95:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  task automatic chk_all;
    check(code, ec);
    check({80'h0, mode}, {80'h0, em});
  endtask : chk_all
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #5;
  endtask : cyc
  task automatic put(input logic [15:0] w);
    u_xdac_host.send(w, 16);
    cyc(12);
  endtask : put
  task automatic test_done;
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done
  ////////////////
  task automatic t_wt;
    put(16'ha5a5);
    put(16'hb3c3);
    ec = {{4{12'h3c3}}, {4{12'h5a5}}};
    chk_all;
    check(96'(u_xdac_host.rx), 96'ha5a5);
    put(16'h0fff);
    // Short frame would leave a write-through of all codes if taken
    u_xdac_host.send(16'h9fff, 15);
    cyc(12);
    put(16'hd777);
    chk_all;
    put(16'he810);
    ec[11:0] = 12'h777;
    ec[95:84] = 12'h777;
    chk_all;
    load_n = 1'b0;
    cyc(8);
    ec = {8{12'h777}};
    chk_all;
    load_n = 1'b1;
    put(16'hc2b4);
    ec = {8{12'h2b4}};
    chk_all;
  endtask : t_wt
  task automatic t_fifo;
    clr_n = 1'b0;
    for (int k = 0; k < 17; k++) put({4'h2 + 4'(k % 8), 12'h100 + 12'(k)});
    check(96'(lost_n), 96'h1);
    check(code, '0);
    clr_n = 1'b1;
    cyc(40);
    ec = '0;
    chk_all;
    put(16'hefff);
    for (int k = 0; k < 8; k++) ec[12*k +: 12] = 12'h108 + 12'(k);
    chk_all;
    put(16'hfffc);
    em = 16'hffff;
    chk_all;
    for (int m = 0; m < 4; m++) begin
      put({4'hf, 8'(1 << m), 2'(m), 2'h0});
      em[2*m +: 2] = 2'(m);
    end
    chk_all;
    put(16'h1000);
    put(16'heff0);
    ec = '0;
    em = '0;
    chk_all;
  endtask : t_fifo
  initial begin
    cyc(5);
    nrst_i = 1'b1;
    cyc(4);
    chk_all;
    t_wt;
    t_fifo;
    test_done;
  end
  initial begin
    #2000000;
    err_total++;
    test_done;
  end
endmodule : octal_dac_serial_register_control_test
`default_nettype wire
